// ### logic/asop_pkg.sv
// Constants for the serial output port of the converter.
// Assumes the master clock is clk_sys_i and software uses Avalon-MM.
// Operation
// R1 - Mode pin high selects self-clocked transfer, low selects external clock.
// R2 - Sampling interval is 16 periods of 64 clocks, half settling, half compute.
// R3 - Self-clocked mode generates the shift clock and drives it with the data.
// R4 - Select polled at each compute period start; if low, send word MSB first.
// R5 - Self-clocked data moves only in compute periods, never in settling periods.
// R6 - Self-clocked: after the LSB, word-ready goes high until a new word.
// R7 - Self-clocked: select high mid-word finishes the bit, then tri-states both.
// R8 - Self-clocked: select low again resumes with the next bit next compute period.
// R9 - Self-clocked: unsent word overtaken raises word-ready four clocks, then loads.
// R10 - Self-clocked: data changes on falling shift clock, receiver samples rising.
// R11 - External mode: select falling enables the data output with MSB valid.
// R12 - External mode: host supplies shift clock; later bits change on its fall.
// R13 - External mode: after the LSB, word-ready and data output go tri-state.
// R14 - External mode: word arriving mid-transfer with select low is discarded.
// R15 - External mode: select high tri-states data at once; resume same bit.
// R16 - External mode: unsent word, select high, new word: ready high four clocks.
// R17 - Host should derive the master clock from its own system clock.
// R18 - Standby input low stops all circuitry into the low-power state; the synchronisers and bus registers keep running.
// R19 - Host should calibrate each time the device leaves standby.
// R20 - Calibrate held high four clocks; starts at fall, ends within 3145655.
// R21 - Word length is a parameter; each transfer shifts exactly that many bits.
package asop_pkg;
  localparam int unsigned WORD_W_DEF     = 16;
  localparam int unsigned PERIOD_CYC     = 64;
  localparam int unsigned PERIODS        = 16;
  localparam int unsigned PHASE_W        = $clog2(PERIOD_CYC * PERIODS);
  localparam int unsigned COMP_BIT       = $clog2(PERIOD_CYC);
  localparam int unsigned SCLK_HALF_CYC  = 4;
  localparam int unsigned BIT_CYC        = 2 * SCLK_HALF_CYC;
  localparam int unsigned BIT_CNT_W      = $clog2(BIT_CYC);
  localparam int unsigned WORD_READY_N_HOLD_CYC  = 4;
  localparam int unsigned HOLD_CNT_W     = 3;
  localparam int unsigned CAL_MIN_HIGH   = 4;
  localparam int unsigned CAL_HI_W       = 3;
  localparam int unsigned CAL_CYCLES_DEF = 3145655;
  localparam int unsigned CAL_CNT_W      = 22;
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [3:0]  REG_WORD       = 4'h8;
  localparam logic        CTRL_EN_RST    = 1'b1;
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned ST_XFER        = 8;
  localparam int unsigned ST_HOLD        = 9;
  localparam int unsigned ST_DONE        = 10;
  localparam int unsigned ST_AVAIL       = 11;
  localparam int unsigned ST_MODE        = 12;
  localparam int unsigned ST_STBY        = 13;
  localparam int unsigned ST_CAL         = 14;
endpackage

// ### logic/asop_top.sv
// Serial output port: shifts finished words out, word-ready, calibrate timer.
// Pins arrive asynchronously; core word comes on clk_sys_i.
`timescale 1ns/1ns
module asop_top
  import asop_pkg::*;
#(
  parameter int unsigned WORD_W     = WORD_W_DEF,
  parameter int unsigned CAL_CYCLES = CAL_CYCLES_DEF
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic [3:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              mode_sel_i,
  input  wire logic              cs_n_i,
  input  wire logic              sclk_i,
  input  wire logic              standby_n_i,
  input  wire logic              cal_i,
  input  wire logic [WORD_W-1:0] core_word_i,
  input  wire logic              core_word_valid_i,
  output logic                   serial_out_o,
  output logic                   serial_out_oe_o,
  output logic                   sclk_o,
  output logic                   sclk_oe_o,
  output logic                   word_ready_n_o,
  output logic                   word_ready_n_oe_o,
  output logic                   cal_busy_o,
  output logic                   low_power_o
);
  localparam int unsigned SENT_W = $clog2(WORD_W + 1);

  typedef struct packed {
    logic                  mode_s1;
    logic                  mode_s2;
    logic                  cs_s1;
    logic                  cs_s2;
    logic                  sck_s1;
    logic                  sck_s2;
    logic                  sck_s3;
    logic                  stby_s1;
    logic                  stby_s2;
    logic                  cal_s1;
    logic                  cal_s2;
    logic                  cal_s3;
    logic [PHASE_W-1:0]    phase;
    logic [WORD_W-1:0]     word;
    logic [WORD_W-1:0]     stage;
    logic [SENT_W-1:0]     sent;
    logic                  avail;
    logic                  done;
    logic                  hold_act;
    logic [HOLD_CNT_W-1:0] hold_cnt;
    logic                  xfer;
    logic [BIT_CNT_W-1:0]  bitc;
    logic                  sdo;
    logic                  sdo_oe;
    logic                  sck;
    logic                  sck_oe;
    logic                  word_ready_n_n;
    logic                  word_ready_n_oe;
    logic [CAL_HI_W-1:0]   cal_hi;
    logic                  cal_busy;
    logic [CAL_CNT_W-1:0]  cal_cnt;
    logic                  ctrl_en;
    logic                  ack;
    logic [31:0]           rdata;
  } asop_state_t;

  asop_state_t s_q;
  asop_state_t s_d;

  logic self_clocked_mode;
  logic external_clocked_mode;
  logic comp;
  logic per_start;
  logic per_last;
  logic sck_fall;
  logic pending;
  logic in_prog;
  logic req;

  // Bit number n counted from the MSB; past the end reads as zero
  function automatic logic bit_at(input logic [WORD_W-1:0] w,
                                  input logic [SENT_W-1:0] n);
    int idx;
    idx = WORD_W - 1 - int'(n);
    bit_at = (idx >= 0) ? w[idx] : 1'b0;
  endfunction

  assign self_clocked_mode     = s_q.mode_s2;  // R1
  assign external_clocked_mode = ~s_q.mode_s2; // R1
  assign comp      = s_q.phase[COMP_BIT];      // R2
  // Polled in the last settling cycle, so eight bits fill compute exactly
  assign per_start = !comp &&
                     (s_q.phase[COMP_BIT-1:0] ==
                      COMP_BIT'(PERIOD_CYC - 1));
  assign per_last  = (s_q.phase[COMP_BIT-1:0] ==
                      COMP_BIT'(PERIOD_CYC - 1));
  assign sck_fall  = s_q.sck_s3 & ~s_q.sck_s2;
  assign pending   = s_q.avail & ~s_q.done;
  assign in_prog   = pending && (s_q.sent != '0);
  assign req       = avs_read_i | avs_write_i;

  always_comb begin
    s_d = s_q;
    // Synchronisers: first stage feeds only the second
    s_d.mode_s1 = mode_sel_i;
    s_d.mode_s2 = s_q.mode_s1;
    s_d.cs_s1   = cs_n_i;
    s_d.cs_s2   = s_q.cs_s1;
    s_d.sck_s1  = sclk_i;
    s_d.sck_s2  = s_q.sck_s1;
    s_d.sck_s3  = s_q.sck_s2;
    s_d.stby_s1 = standby_n_i;
    s_d.stby_s2 = s_q.stby_s1;
    s_d.cal_s1  = cal_i;
    s_d.cal_s2  = s_q.cal_s1;
    s_d.cal_s3  = s_q.cal_s2;

    // Sixteen 64-clock periods wrap naturally in the counter
    s_d.phase = s_q.phase + PHASE_W'(1); // R2

    if (self_clocked_mode) begin
      if (s_q.xfer) begin
        s_d.bitc = s_q.bitc + BIT_CNT_W'(1);
        if (s_q.bitc == BIT_CNT_W'(BIT_CYC - 1)) begin
          s_d.sent = s_q.sent + SENT_W'(1);
          if (s_q.sent == SENT_W'(WORD_W - 1)) begin
            s_d.done = 1'b1; // R6 R21
            s_d.xfer = 1'b0;
          end else if (s_q.cs_s2 || per_last) begin
            // Bit finished before pausing; settling stays quiet
            s_d.xfer = 1'b0; // R5 R7
          end
        end
      end else if (per_start && !s_q.cs_s2 && pending &&
                   s_q.ctrl_en && !s_q.hold_act) begin
        s_d.xfer = 1'b1; // R4 R8
        s_d.bitc = '0;
      end
    end else begin
      s_d.xfer = 1'b0;
      if (sck_fall && !s_q.cs_s2 && pending && s_q.ctrl_en &&
          !s_q.hold_act) begin
        s_d.sent = s_q.sent + SENT_W'(1); // R12
        if (s_q.sent == SENT_W'(WORD_W - 1)) begin
          s_d.done = 1'b1; // R13 R21
        end
      end
    end

    // New word from the core
    if (s_q.hold_act) begin
      if (s_q.hold_cnt == '0) begin
        s_d.hold_act = 1'b0; // R9 R16
        s_d.word     = s_q.stage;
        s_d.avail    = 1'b1;
        s_d.done     = 1'b0;
        s_d.sent     = '0;
        s_d.xfer     = 1'b0;
      end else begin
        s_d.hold_cnt = s_q.hold_cnt - HOLD_CNT_W'(1);
      end
    end else if (core_word_valid_i) begin
      if (external_clocked_mode && !s_q.cs_s2 && in_prog) begin
        s_d.stage = s_q.stage; // R14
      end else if (pending) begin
        s_d.hold_act = 1'b1; // R9 R16
        s_d.hold_cnt = HOLD_CNT_W'(WORD_READY_N_HOLD_CYC - 1);
        s_d.stage    = core_word_i;
        s_d.xfer     = 1'b0;
      end else begin
        s_d.word  = core_word_i;
        s_d.avail = 1'b1;
        s_d.done  = 1'b0;
        s_d.sent  = '0;
      end
    end

    // Pins follow state one cycle later, all from flops
    s_d.sdo = bit_at(s_q.word, s_q.sent); // R11
    if (self_clocked_mode) begin
      s_d.sdo_oe  = s_q.xfer; // R3 R7
      s_d.sck_oe  = s_q.xfer; // R3
      // Low half first: data edge meets the falling clock
      s_d.sck     = !s_q.xfer ||
                    (s_q.bitc >= BIT_CNT_W'(SCLK_HALF_CYC)); // R10
      s_d.word_ready_n_oe = 1'b1;
    end else begin
      s_d.sdo_oe  = !s_q.cs_s2 && pending && s_q.ctrl_en &&
                    !s_q.hold_act; // R11 R13 R15
      s_d.sck_oe  = 1'b0;
      s_d.sck     = 1'b1;
      s_d.word_ready_n_oe = !s_q.done || s_q.hold_act; // R13
    end
    s_d.word_ready_n_n = !pending || s_q.hold_act; // R6 R9

    // Calibrate: high for the minimum, then run on the fall
    if (s_q.cal_s2) begin
      if (s_q.cal_hi != CAL_HI_W'(CAL_MIN_HIGH)) begin
        s_d.cal_hi = s_q.cal_hi + CAL_HI_W'(1);
      end
    end else begin
      s_d.cal_hi = '0;
    end
    if (s_q.cal_s3 && !s_q.cal_s2 &&
        s_q.cal_hi == CAL_HI_W'(CAL_MIN_HIGH)) begin
      s_d.cal_busy = 1'b1; // R20
      s_d.cal_cnt  = CAL_CNT_W'(CAL_CYCLES - 1);
    end else if (s_q.cal_busy) begin
      if (s_q.cal_cnt == '0) begin
        s_d.cal_busy = 1'b0; // R20
      end else begin
        s_d.cal_cnt = s_q.cal_cnt - CAL_CNT_W'(1);
      end
    end

    // Standby halts everything except synchronisers and registers
    if (!s_q.stby_s2) begin
      s_d.phase    = '0; // R18
      s_d.avail    = 1'b0;
      s_d.done     = 1'b0;
      s_d.sent     = '0;
      s_d.xfer     = 1'b0;
      s_d.hold_act = 1'b0;
      s_d.cal_busy = 1'b0;
      s_d.sdo_oe   = 1'b0;
      s_d.sck_oe   = 1'b0;
      s_d.word_ready_n_oe  = 1'b0;
      s_d.word_ready_n_n   = 1'b1;
    end

    // Avalon slave: one wait cycle, action at the released edge
    s_d.ack = req && !s_q.ack;
    if (req && !s_q.ack) begin
      if (avs_address_i == REG_CTRL) begin
        s_d.rdata = 32'h0000_0000;
        s_d.rdata[CTRL_EN_BIT] = s_q.ctrl_en;
      end else if (avs_address_i == REG_STATUS) begin
        s_d.rdata = 32'h0000_0000;
        s_d.rdata[SENT_W-1:0] = s_q.sent;
        s_d.rdata[ST_XFER]    = s_q.xfer;
        s_d.rdata[ST_HOLD]    = s_q.hold_act;
        s_d.rdata[ST_DONE]    = s_q.done;
        s_d.rdata[ST_AVAIL]   = s_q.avail;
        s_d.rdata[ST_MODE]    = s_q.mode_s2;
        s_d.rdata[ST_STBY]    = !s_q.stby_s2;
        s_d.rdata[ST_CAL]     = s_q.cal_busy;
      end else if (avs_address_i == REG_WORD) begin
        s_d.rdata = 32'h0000_0000;
        s_d.rdata[WORD_W-1:0] = s_q.word;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    if (avs_write_i && s_q.ack && avs_address_i == REG_CTRL &&
        avs_byteenable_i[0]) begin
      s_d.ctrl_en = avs_writedata_i[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      s_q          <= '0;
      s_q.stby_s1  <= 1'b1;
      s_q.stby_s2  <= 1'b1;
      s_q.sck      <= 1'b1;
      s_q.word_ready_n_n   <= 1'b1;
      s_q.word_ready_n_oe  <= 1'b1;
      s_q.ctrl_en  <= CTRL_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o    = s_q.rdata;
  assign avs_waitrequest_o = req && !s_q.ack;
  assign serial_out_o      = s_q.sdo;
  assign serial_out_oe_o   = s_q.sdo_oe;
  assign sclk_o            = s_q.sck;
  assign sclk_oe_o         = s_q.sck_oe;
  assign word_ready_n_o    = s_q.word_ready_n_n;
  assign word_ready_n_oe_o = s_q.word_ready_n_oe;
  assign cal_busy_o        = s_q.cal_busy;
  assign low_power_o       = !s_q.stby_s2;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  a_hold_four_clk: assert property ( // R9
    $rose(s_q.hold_act) |-> s_q.hold_act [*4] ##1 !s_q.hold_act)
    else $error("word-ready hold not four clocks");

  a_hold_ready_high: assert property ( // R16
    s_q.hold_act && s_q.stby_s2 |=> word_ready_n_o)
    else $error("word-ready low during hold");

  a_settle_no_xfer: assert property ( // R5
    !comp |-> !s_q.xfer)
    else $error("transfer during settling period");

  a_sck_rise_data: assert property ( // R10
    s_q.sck_oe && $rose(sclk_o) |-> $stable(serial_out_o))
    else $error("data changed on rising shift clock");

  a_ext_cs_tristate: assert property ( // R15
    external_clocked_mode && s_q.cs_s2 |=> !serial_out_oe_o)
    else $error("data driven with select high");

  a_ext_pause_keep: assert property ( // R15
    external_clocked_mode && s_q.cs_s2 && !s_q.hold_act &&
    !core_word_valid_i && s_q.stby_s2 |=> $stable(s_q.sent))
    else $error("bit position moved while paused");

  a_ext_discard_new: assert property ( // R14
    external_clocked_mode && !s_q.cs_s2 && in_prog && !s_q.hold_act &&
    core_word_valid_i && s_q.stby_s2
    |=> !s_q.hold_act && $stable(s_q.word))
    else $error("new word not discarded mid-transfer");

  a_self_start_poll: assert property ( // R4
    self_clocked_mode && per_start && !s_q.cs_s2 && pending &&
    s_q.ctrl_en && !s_q.hold_act && !s_q.xfer && !core_word_valid_i &&
    s_q.stby_s2 |=> s_q.xfer ##1 sclk_oe_o)
    else $error("transfer not started at compute period");

  a_self_done_ready: assert property ( // R6
    self_clocked_mode && s_q.done && s_q.stby_s2 |=> word_ready_n_o)
    else $error("word-ready low after last bit");

  a_ext_done_tri: assert property ( // R13
    external_clocked_mode && s_q.done && !s_q.hold_act
    |=> !word_ready_n_oe_o && !serial_out_oe_o)
    else $error("outputs driven after last bit");

  a_standby_quiet: assert property ( // R18
    !s_q.stby_s2 |=> !s_q.xfer && !s_q.cal_busy ##1 !serial_out_oe_o)
    else $error("activity during standby");
endmodule

// ### test/asop_host_model.sv
// Host side of the serial port: a shift register for self-clocked mode
// and a clock-driving host for external mode.
// Assumes the bench hands in the resolved level of the data pin.
`timescale 1ns/1ns
module asop_host_model #(
  parameter int unsigned W = 16
) (
  input  wire logic clk_sys_i,
  input  wire logic data_i,
  input  wire logic dev_sclk_i,
  input  wire logic dev_sclk_oe_i,
  output logic      host_sclk_o
);
  logic [W-1:0] rx_q = '0;
  int           n_rx = 0;
  logic         sclk_prev = 1'b1;
  initial begin
    host_sclk_o = 1'b1;
  end
  // Sample on the rising shift clock, data settled since the fall
  always @(posedge clk_sys_i) begin
    if (dev_sclk_oe_i && dev_sclk_i && !sclk_prev) begin
      rx_q = {rx_q[W-2:0], data_i};
      n_rx++;
    end
    sclk_prev = dev_sclk_i;
  end
  // Clock idles high between frames; 48 ns per bit
  task automatic ext_read(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (6) @(posedge clk_sys_i);
      rx_q = {rx_q[W-2:0], data_i};
      n_rx++;
      host_sclk_o <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      host_sclk_o <= 1'b1;
    end
  endtask
endmodule

// ### test/tb_adc_serial_output_port.sv
// Self-checking bench for the serial output port.
// Assumes the host model shares clk_sys_i as its system clock.
`timescale 1ns/1ns
module tb_adc_serial_output_port;
  import asop_pkg::*;
  localparam int unsigned CAL_N = 20;
  logic        clk_sys_i, sys_rst_i, avs_read_i, avs_write_i;
  logic [3:0]  avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q;
  logic        avs_waitrequest_o, mode_sel_i, cs_n_i, standby_n_i, cal_i;
  logic [15:0] core_word_i;
  logic        core_word_valid_i, serial_out_o, serial_out_oe_o;
  logic        sclk_o, sclk_oe_o, word_ready_n_o, word_ready_n_oe_o;
  logic        cal_busy_o, low_power_o, host_sclk, serial_out_w;
  logic        serial_out_last = 1'b0;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          k;
  logic [16:0] rows [4] = '{17'h1_A5C3, 17'h0_3C96, 17'h1_8001, 17'h0_7FFE};

  asop_top #(.CAL_CYCLES(CAL_N)) DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .mode_sel_i(mode_sel_i),
    .cs_n_i(cs_n_i), .sclk_i(host_sclk), .standby_n_i(standby_n_i),
    .cal_i(cal_i), .core_word_i(core_word_i),
    .core_word_valid_i(core_word_valid_i), .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o), .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe_o), .word_ready_n_o(word_ready_n_o),
    .word_ready_n_oe_o(word_ready_n_oe_o), .cal_busy_o(cal_busy_o),
    .low_power_o(low_power_o));

  asop_host_model host (
    .clk_sys_i(clk_sys_i), .data_i(serial_out_w), .dev_sclk_i(sclk_o),
    .dev_sclk_oe_i(sclk_oe_o), .host_sclk_o(host_sclk));

  // Released line shows the inverse so a stale bit cannot pass
  always @(posedge clk_sys_i) if (serial_out_oe_o) serial_out_last <= serial_out_o;
  assign serial_out_w = serial_out_oe_o ? serial_out_o : ~serial_out_last;

  // Master clock is the system clock itself
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_read_i      <= !wr;
    avs_write_i     <= wr;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic push(input logic [15:0] w);
    @(posedge clk_sys_i);
    core_word_i       <= w;
    core_word_valid_i <= 1'b1;
    @(posedge clk_sys_i);
    core_word_valid_i <= 1'b0;
  endtask

  task automatic wait_rx(input int n);
    for (int i = 0; i < 3000 && host.n_rx < n; i++) @(posedge clk_sys_i);
  endtask

  task automatic set_pins(input logic m, input logic cs);
    @(posedge clk_sys_i);
    mode_sel_i <= m;
    cs_n_i     <= cs;
    repeat (4) @(posedge clk_sys_i);
    host.n_rx = 0;
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_rst_i = 1'b1;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    mode_sel_i = 1'b1;
    cs_n_i = 1'b1;
    standby_n_i = 1'b1;
    cal_i = 1'b0;
    core_word_i = 16'h0000;
    core_word_valid_i = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk(32'({word_ready_n_o, word_ready_n_oe_o, serial_out_oe_o, sclk_oe_o}),
        32'h0000_000C);
    bus(1'b0, REG_CTRL, 32'h0, q);
    chk(q, 32'h0000_0001);
    bus(1'b1, REG_CTRL, 32'h0000_0000, q);
    bus(1'b0, REG_CTRL, 32'h0, q);
    chk(q, 32'h0000_0000);
    bus(1'b1, REG_CTRL, 32'h0000_0001, q);
    // Write with byte lane 0 off must leave enable set
    avs_byteenable_i <= 4'hE;
    bus(1'b1, REG_CTRL, 32'h0000_0000, q);
    avs_byteenable_i <= 4'hF;
    bus(1'b0, REG_CTRL, 32'h0, q);
    chk(q, 32'h0000_0001);
    bus(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0000_0000);
    foreach (rows[i]) begin
      set_pins(rows[i][16], 1'b1);
      bus(1'b0, REG_STATUS, 32'h0, q);
      chk(32'(q[ST_MODE]), 32'(rows[i][16]));
      push(rows[i][15:0]);
      repeat (6) @(posedge clk_sys_i);
      cs_n_i <= 1'b0;
      if (rows[i][16]) begin
        wait_rx(16);
        chk(32'(host.rx_q), 32'(rows[i][15:0]));
        repeat (300) @(posedge clk_sys_i);
        chk(32'(host.n_rx), 32'h0000_0010);
        chk(32'(word_ready_n_o), 32'h0000_0001);
      end else begin
        repeat (6) @(posedge clk_sys_i);
        host.ext_read(16);
        chk(32'(host.rx_q), 32'(rows[i][15:0]));
        repeat (6) @(posedge clk_sys_i);
        chk(32'({word_ready_n_oe_o, serial_out_oe_o}), 32'h0);
      end
    end
    // Self-clocked pause and resume
    set_pins(1'b1, 1'b1);
    push(16'hC3A5);
    repeat (6) @(posedge clk_sys_i);
    cs_n_i <= 1'b0;
    wait_rx(3);
    cs_n_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    chk(32'({sclk_oe_o, serial_out_oe_o}), 32'h0);
    cs_n_i <= 1'b0;
    wait_rx(16);
    chk(32'(host.rx_q), 32'h0000_C3A5);
    // Unsent word overtaken by a newer one
    set_pins(1'b1, 1'b1);
    push(16'h1234);
    repeat (6) @(posedge clk_sys_i);
    push(16'h5AA5);
    k = 0;
    repeat (12) begin
      @(posedge clk_sys_i);
      if (word_ready_n_o === 1'b1) k++;
    end
    chk(32'(k), 32'h0000_0004);
    cs_n_i <= 1'b0;
    wait_rx(16);
    chk(32'(host.rx_q), 32'h0000_5AA5);
    // External: new word mid-transfer, then select pause
    set_pins(1'b0, 1'b1);
    push(16'hE11E);
    repeat (6) @(posedge clk_sys_i);
    cs_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    host.ext_read(5);
    push(16'h0FF0);
    host.ext_read(3);
    cs_n_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk(32'(serial_out_oe_o), 32'h0);
    cs_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    host.ext_read(8);
    chk(32'(host.rx_q), 32'h0000_E11E);
    standby_n_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    chk(32'(low_power_o), 32'h0000_0001);
    bus(1'b0, REG_STATUS, 32'h0, q);
    chk(32'(q[ST_STBY]), 32'h0000_0001);
    standby_n_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    chk(32'(low_power_o), 32'h0000_0000);
    // Recalibrate after leaving standby
    cal_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    cal_i <= 1'b0;
    for (int i = 0; i < 10 && cal_busy_o !== 1'b1; i++) @(posedge clk_sys_i);
    k = 0;
    while (cal_busy_o === 1'b1 && k < 100) begin
      @(posedge clk_sys_i);
      k++;
    end
    chk(32'(k), 32'(CAL_N));
    tally_and_finish();
  end
endmodule
